// ===== rtl/dmc_mode_control.v
// Mode control of the deinterlacer: register file, start-up load, mode decode, cadence select.
// Assumes an Avalon-MM master on clk_in and a video stream synchronous to clk_in.
`timescale 1ns/1ps
`include "dmc_consts.vh"

// Functional notes
// - Internal memory clock source means doubled input clock; only valid below 36 MHz.
// - Ratio bit set: output clock equals input; clear: output runs twice input.
// - Commanded reset bit holds the device in reset until software clears it.
// - When enabled, lines first through last of each field are blanked.
// - Blanking happens on incoming video before any processing stage.
// - First and last blank lines are each 8-bit host fields.
// - Noise reduction level is an 8-bit field, 256 steps.
// - Detail enhancement level is a 10-bit field, high-pass plus nonlinear boost.
// - Reset pin low returns all logic and registers to defaults.
// - Standard and mode pins are captured at reset release and used thereafter.
// - Mode comes from pins or the host mode field at bits 7 to 5.
// - Mode codes: adaptive, pulldown, film 24p, film segmented, reserved, pass.
// - Adaptive mode with segmented-frame standard converts segmented to progressive.
// - Pulldown mode merges fields on detected cadence, else vertical-temporal processing.
// - Cadence source bit zero: internal detection; one: external code pins.
// - External cadence codes A to F force vertical-temporal fallback.
// - Film mode drops repeated fields, outputs 24 Hz progressive, no filtering.
// - Film modes always use external cadence, compensation on, source bit ignored; the code forces merge on and never reads the cadence code pins.
// - Film segmented mode is like film mode with segmented-frame output.
// - Pass mode passes active video only, ancillary dropped, buffers in use.
module dmc_mode_control #(
	parameter DATA_W        = 20,
	parameter INPUT_MHZ     = 27,
	parameter [4:0] SF_STD  = 5'h10
) (
	// Clock and reset
	input  wire              clk_in,
	input  wire              resetn_in,
	// Avalon-MM slave
	input  wire [9:0]        avs_address_in,
	input  wire              avs_read_in,
	input  wire              avs_write_in,
	input  wire [31:0]       avs_writedata_in,
	input  wire [3:0]        avs_byteenable_in,
	output reg  [31:0]       avs_readdata_out,
	output reg               avs_waitrequest_out,
	// Strap pins
	input  wire [4:0]        std_pins_in,
	input  wire [2:0]        mode_pins_in,
	// Cadence
	input  wire [3:0]        external_cadence_code_in,
	input  wire              internal_cadence_lock_in,
	// Video stream in
	input  wire              valid_in,
	input  wire              sol_in,
	input  wire              sof_in,
	input  wire [DATA_W-1:0] data_in,
	// Video stream out, to processing
	output reg               valid_out,
	output reg               sol_out,
	output reg               sof_out,
	output reg  [DATA_W-1:0] data_out,
	// Processing controls
	output reg               memory_clock_source_select_out,
	output reg               doubler_out_of_range_out,
	output reg               output_clock_ratio_select_out,
	output reg               hd_clock_ratio_select_out,
	output reg               pipeline_run_out,
	output reg  [2:0]        active_mode_out,
	output reg  [4:0]        video_standard_select_out,
	output reg               field_merge_out,
	output reg               vertical_temporal_processing_out,
	output reg               film_output_out,
	output reg               segmented_output_out,
	output reg               segmented_input_out,
	output reg               filter_bypass_out,
	output reg               drop_ancillary_out,
	output reg  [7:0]        noise_reduction_level_out,
	output reg  [9:0]        detail_enhancement_level_out
);

	// ****************************************
	// Register storage
	// ****************************************
	reg [15:0] mode_word_reg;
	reg [15:0] field2_end_reg;
	reg [15:0] clock_src_reg;
	reg [15:0] run_reset_reg;
	reg        blank_en_reg;
	reg [7:0]  blank_first_reg;
	reg [7:0]  blank_last_reg;
	reg [7:0]  noise_reg;
	reg [9:0]  detail_reg;
	reg        strap_pending_reg;
	reg        ack_reg;

	// Doubler limit is a property of the board clock, flagged not enforced.
	localparam DOUBLER_BAD = (INPUT_MHZ >= `DMC_DOUBLER_MAX_MHZ) ? 1'b1 : 1'b0;

	wire [7:0] word_idx = avs_address_in[9:2];
	wire       req      = (avs_read_in || avs_write_in) && !ack_reg;
	// A write lands on the edge at which the master sees waitrequest low.
	wire       wr       = avs_write_in && ack_reg;
	wire       cmd_rst  = run_reset_reg[`DMC_CMD_RESET_BIT];

	// Byte-lane merge of a 16-bit register.
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  be;
		begin
			merge16[7:0]  = be[0] ? wd[7:0]  : old[7:0];
			merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	// ****************************************
	// Avalon slave: one wait state, then acknowledge
	// ****************************************
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_reg             <= 1'b0;
			avs_waitrequest_out <= 1'b1;
		end else begin
			ack_reg             <= req;
			avs_waitrequest_out <= !req;
		end
	end

	// Straps are caught on the first clock after reset release, not under reset.
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			strap_pending_reg <= 1'b1;
			mode_word_reg     <= 16'h0000;
			field2_end_reg    <= `DMC_RST_FIELD2_END;
			clock_src_reg     <= `DMC_RST_CLOCK_SRC;
			run_reset_reg     <= `DMC_RST_RUN_RESET;
			blank_en_reg      <= 1'b0;
			blank_first_reg   <= 8'h00;
			blank_last_reg    <= 8'h00;
			noise_reg         <= `DMC_RST_NOISE;
			detail_reg        <= `DMC_RST_DETAIL;
		end else begin
			if (strap_pending_reg) begin
				strap_pending_reg <= 1'b0;
				mode_word_reg[`DMC_STD_MSB:`DMC_STD_LSB]   <= std_pins_in;
				mode_word_reg[`DMC_MODE_MSB:`DMC_MODE_LSB] <= mode_pins_in;
			end else if (wr) begin
				case (word_idx)
					`DMC_IDX_MODE_WORD: begin
						mode_word_reg <= merge16(mode_word_reg, avs_writedata_in,
							avs_byteenable_in);
					end
					`DMC_IDX_FIELD2_END: begin
						field2_end_reg <= merge16(field2_end_reg, avs_writedata_in,
							avs_byteenable_in);
					end
					`DMC_IDX_CLOCK_SRC: begin
						clock_src_reg <= merge16(clock_src_reg, avs_writedata_in,
							avs_byteenable_in);
					end
					`DMC_IDX_RUN_RESET: begin
						// Software or the reset pin clears the commanded reset.
						run_reset_reg <= merge16(run_reset_reg, avs_writedata_in,
							avs_byteenable_in);
					end
					`DMC_IDX_BLANK_CTRL: begin
						if (avs_byteenable_in[0]) begin
							blank_first_reg <= avs_writedata_in[7:0];
						end
						if (avs_byteenable_in[1]) begin
							blank_last_reg <= avs_writedata_in[15:8];
						end
						if (avs_byteenable_in[2]) begin
							blank_en_reg <= avs_writedata_in[`DMC_BLANK_EN_BIT];
						end
					end
					`DMC_IDX_ENHANCE: begin
						if (avs_byteenable_in[0]) begin
							noise_reg <= avs_writedata_in[7:0];
						end
						if (avs_byteenable_in[2]) begin
							detail_reg[7:0] <= avs_writedata_in[23:16];
						end
						if (avs_byteenable_in[3]) begin
							detail_reg[9:8] <= avs_writedata_in[25:24];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if (avs_read_in && !ack_reg) begin
			case (word_idx)
				`DMC_IDX_MODE_WORD:  avs_readdata_out <= {16'h0000, mode_word_reg};
				`DMC_IDX_FIELD2_END: avs_readdata_out <= {16'h0000, field2_end_reg};
				`DMC_IDX_CLOCK_SRC:  avs_readdata_out <= {16'h0000, clock_src_reg};
				`DMC_IDX_RUN_RESET:  avs_readdata_out <= {16'h0000, run_reset_reg};
				`DMC_IDX_BLANK_CTRL: avs_readdata_out <= {15'h0000, blank_en_reg,
					blank_last_reg, blank_first_reg};
				`DMC_IDX_ENHANCE:    avs_readdata_out <= {6'h00, detail_reg, 8'h00,
					noise_reg};
				`DMC_IDX_STATUS:     avs_readdata_out <= {20'h00000,
					vertical_temporal_processing_out, field_merge_out,
					pipeline_run_out, doubler_out_of_range_out, active_mode_out,
					video_standard_select_out};
				default:             avs_readdata_out <= 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	wire [2:0] mode_sel = mode_word_reg[`DMC_MODE_MSB:`DMC_MODE_LSB];
	wire [4:0] std_sel  = mode_word_reg[`DMC_STD_MSB:`DMC_STD_LSB];
	wire       cad_ext  = mode_word_reg[`DMC_CAD_SRC_BIT];
	wire       run_ok   = !cmd_rst && !strap_pending_reg;

	reg merge_n;
	reg vt_n;
	reg film_n;
	reg seg_out_n;
	reg seg_in_n;
	reg bypass_n;
	reg pass_n;
	reg ext_valid;

	always @* begin
		merge_n   = 1'b0;
		vt_n      = 1'b0;
		film_n    = 1'b0;
		seg_out_n = 1'b0;
		seg_in_n  = 1'b0;
		bypass_n  = 1'b0;
		pass_n    = 1'b0;
		ext_valid = (external_cadence_code_in < `DMC_CAD_INVALID_MIN);
		case (mode_sel)
			`DMC_MODE_ADAPTIVE: begin
				vt_n     = 1'b1;
				seg_in_n = (std_sel == SF_STD);
			end
			`DMC_MODE_PULLDOWN: begin
				if (cad_ext) begin
					merge_n = ext_valid;
				end else begin
					merge_n = internal_cadence_lock_in;
				end
				vt_n = !merge_n;
			end
			`DMC_MODE_FILM_P, `DMC_MODE_FILM_SF: begin
				// Film expects the external code, but neither the code pins nor the source bit are read; compensation stays on.
				film_n    = 1'b1;
				merge_n   = 1'b1;
				bypass_n  = 1'b1;
				seg_out_n = (mode_sel == `DMC_MODE_FILM_SF);
			end
			`DMC_MODE_PASS: begin
				// Field buffers still run, so the pipeline must be programmed.
				bypass_n = 1'b1;
				pass_n   = 1'b1;
			end
			default: begin
				vt_n = 1'b1;
			end
		endcase
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			memory_clock_source_select_out   <= 1'b0;
			doubler_out_of_range_out         <= 1'b0;
			output_clock_ratio_select_out    <= 1'b0;
			hd_clock_ratio_select_out        <= 1'b0;
			pipeline_run_out                 <= 1'b0;
			active_mode_out                  <= 3'h0;
			video_standard_select_out        <= 5'h00;
			field_merge_out                  <= 1'b0;
			vertical_temporal_processing_out <= 1'b0;
			film_output_out                  <= 1'b0;
			segmented_output_out             <= 1'b0;
			segmented_input_out              <= 1'b0;
			filter_bypass_out                <= 1'b0;
			drop_ancillary_out               <= 1'b0;
			noise_reduction_level_out        <= 8'h00;
			detail_enhancement_level_out     <= 10'h000;
		end else begin
			memory_clock_source_select_out <= clock_src_reg[`DMC_MEMCLK_BIT];
			// Internal doubler chosen while the input clock is too fast.
			doubler_out_of_range_out <= !clock_src_reg[`DMC_MEMCLK_BIT] && DOUBLER_BAD;
			output_clock_ratio_select_out <= clock_src_reg[`DMC_OCLK_RATIO_BIT];
			hd_clock_ratio_select_out     <= clock_src_reg[`DMC_HD_RATIO_BIT];
			// Begin bit gates the pipeline; host orders it after timing setup.
			pipeline_run_out <= run_ok && run_reset_reg[`DMC_BEGIN_BIT];
			active_mode_out                  <= mode_sel;
			video_standard_select_out        <= std_sel;
			field_merge_out                  <= run_ok && merge_n;
			vertical_temporal_processing_out <= run_ok && vt_n;
			film_output_out                  <= film_n;
			segmented_output_out             <= seg_out_n;
			segmented_input_out              <= seg_in_n;
			filter_bypass_out                <= bypass_n;
			drop_ancillary_out               <= pass_n;
			noise_reduction_level_out        <= noise_reg;
			detail_enhancement_level_out     <= detail_reg;
		end
	end

	// ****************************************
	// Input stream: blanking first, then reset gating
	// ****************************************
	wire              bl_valid;
	wire              bl_sol;
	wire              bl_sof;
	wire [DATA_W-1:0] bl_data;

	dmc_line_blank #(
		.DATA_W (DATA_W),
		.LINE_W (8)
	) u_blank (
		.clk_in        (clk_in),
		.resetn_in     (resetn_in),
		.enable_in     (blank_en_reg),
		.first_line_in (blank_first_reg),
		.last_line_in  (blank_last_reg),
		.valid_in      (valid_in),
		.sol_in        (sol_in),
		.sof_in        (sof_in),
		.data_in       (data_in),
		.valid_out     (bl_valid),
		.sol_out       (bl_sol),
		.sof_out       (bl_sof),
		.data_out      (bl_data)
	);

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			valid_out <= 1'b0;
			sol_out   <= 1'b0;
			sof_out   <= 1'b0;
			data_out  <= {DATA_W{1'b0}};
		end else begin
			valid_out <= bl_valid && run_ok;
			sol_out   <= bl_sol && run_ok;
			sof_out   <= bl_sof && run_ok;
			data_out  <= run_ok ? bl_data : {DATA_W{1'b0}};
		end
	end

endmodule

// ===== rtl/dmc_consts.vh
// Register offsets, field positions, reset values and mode codes of the mode control block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef DMC_CONSTS_VH
`define DMC_CONSTS_VH

// ****************************************
// Register word indices (byte address is four times the index)
// ****************************************
`define DMC_IDX_MODE_WORD     8'h00
`define DMC_IDX_FIELD2_END    8'h1D
`define DMC_IDX_CLOCK_SRC     8'h1E
`define DMC_IDX_RUN_RESET     8'h1F
`define DMC_IDX_BLANK_CTRL    8'h20
`define DMC_IDX_ENHANCE       8'h21
`define DMC_IDX_STATUS        8'h22

// ****************************************
// Field positions
// ****************************************
`define DMC_MODE_LSB          5
`define DMC_MODE_MSB          7
`define DMC_STD_LSB           0
`define DMC_STD_MSB           4
`define DMC_CAD_SRC_BIT       8
`define DMC_MEMCLK_BIT        0
`define DMC_OCLK_RATIO_BIT    1
`define DMC_HD_RATIO_BIT      2
`define DMC_BEGIN_BIT         0
`define DMC_CMD_RESET_BIT     15
`define DMC_BLANK_EN_BIT      16

// ****************************************
// Reset values
// ****************************************
`define DMC_RST_CLOCK_SRC     16'h0000
`define DMC_RST_RUN_RESET     16'h0000
`define DMC_RST_FIELD2_END    16'h0000
`define DMC_RST_NOISE         8'h00
`define DMC_RST_DETAIL        10'h000

// ****************************************
// Operating modes
// ****************************************
`define DMC_MODE_ADAPTIVE     3'h0
`define DMC_MODE_PULLDOWN     3'h1
`define DMC_MODE_FILM_P       3'h2
`define DMC_MODE_FILM_SF      3'h3
`define DMC_MODE_PASS         3'h7

// Cadence codes at or above this are invalid.
`define DMC_CAD_INVALID_MIN   4'hA

// Internal clock doubler limit, MHz.
`define DMC_DOUBLER_MAX_MHZ   36

`endif

// ===== rtl/dmc_line_blank.v
// Input-side line blanking stage, placed ahead of all processing.
// Assumes a pixel stream with valid, start-of-line and start-of-field marks on clk_in.
`timescale 1ns/1ps

module dmc_line_blank #(
	parameter DATA_W = 20,
	parameter LINE_W = 8
) (
	// Clock and reset
	input  wire              clk_in,
	input  wire              resetn_in,
	// Control
	input  wire              enable_in,
	input  wire [LINE_W-1:0] first_line_in,
	input  wire [LINE_W-1:0] last_line_in,
	// Stream in
	input  wire              valid_in,
	input  wire              sol_in,
	input  wire              sof_in,
	input  wire [DATA_W-1:0] data_in,
	// Stream out
	output reg               valid_out,
	output reg               sol_out,
	output reg               sof_out,
	output reg  [DATA_W-1:0] data_out
);

	// Line count saturates so that long fields never wrap back into the window.
	reg [LINE_W:0] line_reg;
	reg [LINE_W:0] cur_line;
	reg            blank_now;

	always @* begin
		if (valid_in && sof_in) begin
			cur_line = {{LINE_W{1'b0}}, 1'b1};
		end else if (valid_in && sol_in && !line_reg[LINE_W]) begin
			cur_line = line_reg + {{LINE_W{1'b0}}, 1'b1};
		end else begin
			cur_line = line_reg;
		end
		blank_now = enable_in && !cur_line[LINE_W] &&
			(cur_line[LINE_W-1:0] >= first_line_in) &&
			(cur_line[LINE_W-1:0] <= last_line_in);
	end

	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_reg  <= {(LINE_W+1){1'b0}};
			valid_out <= 1'b0;
			sol_out   <= 1'b0;
			sof_out   <= 1'b0;
			data_out  <= {DATA_W{1'b0}};
		end else begin
			line_reg  <= cur_line;
			valid_out <= valid_in;
			sol_out   <= sol_in;
			sof_out   <= sof_in;
			data_out  <= blank_now ? {DATA_W{1'b0}} : data_in;
		end
	end

endmodule

// ===== testbench/dmc_video_source.sv
// Interlaced source model: fields of 8 lines, 4 pixels a line, 2 idle cycles after each.
// Assumes the bench starts and stops it through run_in, on clk_in.
`timescale 1ns/1ps
module dmc_video_source (
	// Clock and control
	input  logic        clk_in,
	input  logic        resetn_in,
	input  logic        run_in,
	// Stream
	output logic        valid_out,
	output logic        sol_out,
	output logic        sof_out,
	output logic [19:0] data_out
);
	logic [3:0] px_reg;
	logic [3:0] ln_reg;

	// Idle data toggles so that a stale value is never taken for a pixel.
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			px_reg <= 4'h0;
			ln_reg <= 4'h0;
			valid_out <= 1'b0;
			sol_out <= 1'b0;
			sof_out <= 1'b0;
			data_out <= 20'h0;
		end else begin
			valid_out <= run_in && px_reg < 4'h4;
			sol_out <= run_in && px_reg == 4'h0;
			sof_out <= run_in && px_reg == 4'h0 && ln_reg == 4'h0;
			data_out <= (run_in && px_reg < 4'h4) ? {12'hA50, ln_reg, px_reg} : ~data_out;
			if (run_in) begin
				px_reg <= (px_reg == 4'h5) ? 4'h0 : px_reg + 4'h1;
				if (px_reg == 4'h5)
					ln_reg <= (ln_reg == 4'h7) ? 4'h0 : ln_reg + 4'h1;
			end
		end
	end
endmodule

// ===== testbench/dmc_mode_control_properties.sv
// Port assertions of the mode control block.
// Assumes a bind from the bench top; one clock, reset active low.
`timescale 1ns/1ps
module dmc_mode_control_properties #(
	parameter DATA_W    = 20,
	parameter INPUT_MHZ = 27
) (
	// Clock, reset, bus
	input logic              clk_in,
	input logic              resetn_in,
	input logic              avs_read_in,
	input logic              avs_write_in,
	input logic              avs_waitrequest_out,
	// Cadence and stream
	input logic [3:0]        external_cadence_code_in,
	input logic              internal_cadence_lock_in,
	input logic              sof_in,
	input logic              sof_out,
	input logic              valid_out,
	input logic [DATA_W-1:0] data_out,
	// Controls
	input logic              pipeline_run_out,
	input logic [2:0]        active_mode_out,
	input logic              field_merge_out,
	input logic              vertical_temporal_processing_out,
	input logic              film_output_out,
	input logic              segmented_output_out,
	input logic              filter_bypass_out,
	input logic              drop_ancillary_out,
	input logic              memory_clock_source_select_out,
	input logic              doubler_out_of_range_out
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	property p_ack;
		$rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out;
	endproperty
	property p_doubler;
		(memory_clock_source_select_out || INPUT_MHZ < 36)[*2] |-> !doubler_out_of_range_out;
	endproperty
	property p_gate;
		// Outside commanded reset merge or vertical-temporal is up, pass mode aside.
		(!pipeline_run_out && !field_merge_out && !vertical_temporal_processing_out &&
			active_mode_out != 3'h7)[*3] |-> !valid_out && data_out == 0;
	endproperty
	property p_lat;
		pipeline_run_out[*4] |-> sof_out == $past(sof_in, 2);
	endproperty
	property p_adapt;
		(active_mode_out == 3'h0 && pipeline_run_out)[*2] |-> !field_merge_out && !film_output_out;
	endproperty
	property p_film;
		(active_mode_out == 3'h2)[*2] |-> film_output_out && filter_bypass_out && !segmented_output_out;
	endproperty
	property p_seg;
		(active_mode_out == 3'h3)[*2] |-> film_output_out && segmented_output_out;
	endproperty
	property p_pass;
		(active_mode_out == 3'h7)[*2] |-> drop_ancillary_out;
	endproperty
	property p_cad;
		(active_mode_out == 3'h1 && pipeline_run_out && external_cadence_code_in >= 4'hA &&
			!internal_cadence_lock_in)[*3] |-> vertical_temporal_processing_out && !field_merge_out;
	endproperty
	property p_film_merge;
		(active_mode_out == 3'h2 && pipeline_run_out)[*2] |-> field_merge_out;
	endproperty

	a_ack: assert property (p_ack) else $error("bus answer late");
	a_doubler: assert property (p_doubler) else $error("doubler flag wrong");
	a_gate: assert property (p_gate) else $error("stream not gated");
	a_lat: assert property (p_lat) else $error("stream latency wrong");
	a_adapt: assert property (p_adapt) else $error("adaptive decode wrong");
	a_film: assert property (p_film) else $error("film decode wrong");
	a_seg: assert property (p_seg) else $error("segmented film decode wrong");
	a_pass: assert property (p_pass) else $error("pass decode wrong");
	a_cad: assert property (p_cad) else $error("cadence fallback wrong");
	a_film_merge: assert property (p_film_merge) else $error("film merge off");

	c_pass: cover property (drop_ancillary_out);
	c_seg: cover property (segmented_output_out);
	c_merge: cover property (field_merge_out && pipeline_run_out);
endmodule

// ===== testbench/tb_dmc_mode_control.sv
// Bench of the mode control block: bus tasks, scenario tasks, stream monitor.
// Assumes the source model and the checker file compiled before it.
`timescale 1ns/1ps
module tb_dmc_mode_control;
	logic        clk_in = 0;
	logic        resetn_in = 0;
	logic [9:0]  avs_address_in = 0;
	logic        avs_read_in = 0;
	logic        avs_write_in = 0;
	logic [31:0] avs_writedata_in = 0;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic [4:0]  std_pins_in = 5'h04;
	logic [2:0]  mode_pins_in = 3'h7;
	logic [3:0]  cad_in = 0;
	logic        lock_in = 0;
	logic        src_run = 0;
	logic        mon = 0;
	logic        valid_in, sol_in, sof_in, valid_out, sol_out, sof_out;
	logic [19:0] data_in, data_out, e1, e2;
	logic        s1, s2;
	logic        memclk, doubler, ratio, hd, run, merge, vt, film, segout, segin, bypass, drop;
	logic [2:0]  mode;
	logic [4:0]  std;
	logic [7:0]  noise;
	logic [9:0]  detail;
	logic [31:0] rd;
	integer      err_count = 0, comparisons = 0, cycles = 0, ln = 0;

	dmc_video_source SRC (.clk_in(clk_in), .resetn_in(resetn_in), .run_in(src_run),
		.valid_out(valid_in), .sol_out(sol_in), .sof_out(sof_in), .data_out(data_in));

	dmc_mode_control #(.DATA_W(20), .INPUT_MHZ(27), .SF_STD(5'h10)) DUT (
		.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hF),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.std_pins_in(std_pins_in), .mode_pins_in(mode_pins_in),
		.external_cadence_code_in(cad_in), .internal_cadence_lock_in(lock_in),
		.valid_in(valid_in), .sol_in(sol_in), .sof_in(sof_in), .data_in(data_in),
		.valid_out(valid_out), .sol_out(sol_out), .sof_out(sof_out), .data_out(data_out),
		.memory_clock_source_select_out(memclk), .doubler_out_of_range_out(doubler),
		.output_clock_ratio_select_out(ratio), .hd_clock_ratio_select_out(hd),
		.pipeline_run_out(run), .active_mode_out(mode), .video_standard_select_out(std),
		.field_merge_out(merge), .vertical_temporal_processing_out(vt),
		.film_output_out(film), .segmented_output_out(segout), .segmented_input_out(segin),
		.filter_bypass_out(bypass), .drop_ancillary_out(drop),
		.noise_reduction_level_out(noise), .detail_enhancement_level_out(detail));

	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons = comparisons + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task end_sim;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task cyc(input integer n);
		repeat (n) @(posedge clk_in);
	endtask

	// Holds the request until waitrequest is seen low, then lets one edge pass.
	task bus(input logic w, input logic [7:0] i, input logic [31:0] d);
		avs_address_in <= {i, 2'b00};
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0)
			@(posedge clk_in);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task wr(input logic [7:0] i, input logic [31:0] d);
		bus(1'b1, i, d);
	endtask

	task rc(input logic [7:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h0);
		chk(rd, e);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_straps;
		std_pins_in <= 5'h1F;
		cyc(2);
		chk(std, 5'h04);
		chk(mode, 3'h7);
		chk(drop, 1'b1);
		rc(8'h00, 32'h0000_00E4);
		rc(8'h1F, 32'h0);
		rc(8'h1E, 32'h0);
	endtask

	task t_regs;
		wr(8'h1E, 32'h6);
		cyc(2);
		chk({hd, ratio, memclk, doubler}, 4'hC);
		wr(8'h1E, 32'h1);
		cyc(2);
		chk({hd, ratio, memclk, doubler}, 4'h2);
		wr(8'h21, 32'h03FF_00A5);
		cyc(2);
		chk(noise, 8'hA5);
		chk(detail, 10'h3FF);
		rc(8'h21, 32'h03FF_00A5);
		wr(8'hF0, 32'hFFFF_FFFF);
		rc(8'hF0, 32'h0);
	endtask

	task t_modes;
		integer k;
		logic [2:0] m;
		for (k = 0; k < 6; k = k + 1) begin
			m = (k == 4) ? 3'h7 : k[2:0];
			wr(8'h00, {24'h0, m, 5'h10});
			cyc(3);
			chk(mode, m);
			chk({film, segout, drop}, {m == 3'h2 || m == 3'h3, m == 3'h3, m == 3'h7});
			if (m == 3'h0)
				chk(segin, 1'b1);
			if (m == 3'h2 || m == 3'h3)
				chk(bypass, 1'b1);
		end
		wr(8'h00, 32'h0);
		cyc(3);
		chk(segin, 1'b0);
	endtask

	task t_cad;
		integer c;
		wr(8'h1F, 32'h1);
		lock_in <= 1'b1;
		cad_in <= 4'hF;
		wr(8'h00, 32'h20);
		cyc(3);
		chk({merge, vt}, 2'b10);
		lock_in <= 1'b0;
		cyc(3);
		chk({merge, vt}, 2'b01);
		lock_in <= 1'b1;
		wr(8'h00, 32'h120);
		for (c = 10; c < 16; c = c + 1) begin
			cad_in <= c[3:0];
			cyc(3);
			chk({merge, vt}, 2'b01);
		end
		cad_in <= 4'h9;
		lock_in <= 1'b0;
		cyc(3);
		chk({merge, vt}, 2'b10);
		wr(8'h00, 32'h40);
		cyc(3);
		chk({merge, film}, 2'b11);
	endtask

	task t_blank;
		wr(8'h20, 32'h0001_0503);
		wr(8'h00, 32'h0);
		src_run <= 1'b1;
		cyc(10);
		mon <= 1'b1;
		cyc(150);
		mon <= 1'b0;
	endtask

	task t_cmd_reset;
		wr(8'h1F, 32'h8001);
		cyc(3);
		repeat (40) begin
			@(posedge clk_in);
			chk({run, merge, vt, valid_out, data_out}, 32'h0);
		end
		rc(8'h21, 32'h03FF_00A5);
		wr(8'h1F, 32'h1);
		cyc(3);
		chk(run, 1'b1);
		resetn_in <= 1'b0;
		cyc(2);
		chk({run, noise, detail, valid_out}, 32'h0);
		resetn_in <= 1'b1;
		cyc(2);
		rc(8'h21, 32'h0);
		rc(8'h1F, 32'h0);
	endtask

	// ****************************************
	// Clock, monitor, sequence
	// ****************************************
	initial
		forever #4 clk_in = ~clk_in;

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (valid_in && sof_in)
			ln = 1;
		else if (valid_in && sol_in)
			ln = ln + 1;
		e1 <= (ln >= 3 && ln <= 5) ? 20'h0 : data_in;
		e2 <= e1;
		s1 <= sol_in;
		s2 <= s1;
		if (mon && valid_out) begin
			chk(data_out, e2);
			chk(sol_out, s2);
		end
		if (cycles == 5000) begin
			err_count = err_count + 1;
			end_sim;
		end
	end

	initial begin
		cyc(10);
		resetn_in <= 1'b1;
		cyc(2);
		t_straps;
		t_regs;
		t_modes;
		t_cad;
		t_blank;
		t_cmd_reset;
		end_sim;
	end
endmodule

bind dmc_mode_control dmc_mode_control_properties #(.DATA_W(DATA_W), .INPUT_MHZ(INPUT_MHZ)) u_props (
	.clk_in, .resetn_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
	.external_cadence_code_in, .internal_cadence_lock_in, .sof_in, .sof_out, .valid_out,
	.data_out, .pipeline_run_out, .active_mode_out, .field_merge_out,
	.vertical_temporal_processing_out, .film_output_out, .segmented_output_out,
	.filter_bypass_out, .drop_ancillary_out, .memory_clock_source_select_out,
	.doubler_out_of_range_out);
